// ===== hdl/soae_alu_exec.sv
// single operand instruction path with two operand flag handling
// assumes instructions arrive synchronous to clk from a microcode store
`timescale 1ns/1ps
`include "soae_cfg.svh"

module soae_alu_exec (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr,
   input  wire logic [15:0] data_in,
   input  wire logic [15:0] imm_in,
   input  wire logic        y_oe_n,
   output logic      [15:0] y_out,
   output logic             y_drive_n,
   output logic      [15:0] accumulator,
   output logic      [7:0]  condition_flags
);

   soae_pkg::soae_instr_t ins;
   soae_pkg::soae_op_t    op;
   soae_pkg::soae_alu_t   alu;
   soae_pkg::soae_dest_t  dst;

   logic [15:0] ram_r [`SOAE_RAM_WORDS];
   logic [15:0] ram_nxt [`SOAE_RAM_WORDS];
   logic [15:0] acc_r;
   logic [15:0] acc_nxt;
   logic [7:0]  flg_r;
   logic [7:0]  flg_nxt;
   logic [15:0] y_r;
   logic [15:0] y_nxt;
   logic        ydrv_n_r;
   logic [15:0] src_a;
   logic [15:0] src_b;
   logic [15:0] ram_word;
   logic        ydrv_n_nxt;

   // source mux shared by both single operand formats
   function automatic logic [15:0] pick_src(input logic [3:0]  sel,
                                            input logic [15:0] ram,
                                            input logic [15:0] acc,
                                            input logic [15:0] d,
                                            input logic [15:0] imm);
      logic [15:0] s;
      s = `SOAE_WORD_RST;
      case (sel)
         `SOAE_SEL_ACC:  s = acc;
         `SOAE_SEL_DATA: s = d;
         `SOAE_SEL_IMM:  s = imm;
         `SOAE_SEL_ZERO: s = `SOAE_WORD_RST;
         `SOAE_SEL_DZE:  s = {8'h00, d[7:0]};
         `SOAE_SEL_DSE:  s = {{8{d[7]}}, d[7:0]};
         default:        s = ram;
      endcase
      return s;
   endfunction

   // adder with width-correct carry and overflow for byte or word
   function automatic soae_pkg::soae_alu_t add3(input logic        word,
                                                input logic [15:0] a,
                                                input logic [15:0] b,
                                                input logic        cin);
      soae_pkg::soae_alu_t o;
      logic [16:0] w;
      logic [8:0]  bt;
      w = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
      bt = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
      o.res = word ? w[15:0] : {8'h00, bt[7:0]};
      if (word) begin
         o.c = w[16];
         o.v = (a[15] == b[15]) && (w[15] != a[15]);
      end else begin
         o.c = bt[8];
         o.v = (a[7] == b[7]) && (bt[7] != a[7]);
      end
      o.n = word ? o.res[15] : o.res[7];
      o.z = word ? (o.res == 16'h0000) : (o.res[7:0] == 8'h00);
      return o;
   endfunction

   // logic result: v and c forced low
   function automatic soae_pkg::soae_alu_t logic_res(input logic        word,
                                                     input logic [15:0] r);
      soae_pkg::soae_alu_t o;
      // byte mode shows only the low byte, as the adder path does
      o.res = word ? r : {8'h00, r[7:0]};
      o.v = 1'b0;
      o.c = 1'b0;
      o.n = word ? r[15] : r[7];
      o.z = word ? (r == 16'h0000) : (r[7:0] == 8'h00);
      return o;
   endfunction

   // field split
   always_comb begin
      ins.word_mode = instr[`SOAE_BW_BIT];
      ins.quad      = instr[`SOAE_QUAD_HI:`SOAE_QUAD_LO];
      ins.opcode    = instr[`SOAE_OPC_HI:`SOAE_OPC_LO];
      ins.sel       = instr[`SOAE_SEL_HI:`SOAE_SEL_LO];
      ins.addr      = instr[`SOAE_ADDR_HI:`SOAE_ADDR_LO];
      op            = soae_pkg::soae_op_t'(ins.opcode);
      ram_word      = ram_r[ins.addr];
   end

   // destination decode per quadrant
   always_comb begin
      dst = '0;
      if (instr_valid) begin
         unique case (ins.quad)
            `SOAE_QUAD_RAM: begin
               if (op >= soae_pkg::SOAE_OP_PASS) begin
                  dst.valid = 1'b1;
                  case (ins.sel)
                     `SOAE_SEL_RAM_ACC: begin
                        dst.to_acc = 1'b1;
                     end
                     `SOAE_SEL_RAM_Y:   ;
                     `SOAE_SEL_RAM_FLG: begin
                        dst.to_flg = 1'b1;
                     end
                     `SOAE_SEL_RAM_RAM: begin
                        dst.to_ram = 1'b1;
                     end
                     `SOAE_SEL_ACC, `SOAE_SEL_DATA, `SOAE_SEL_IMM,
                     `SOAE_SEL_ZERO, `SOAE_SEL_DZE, `SOAE_SEL_DSE:
                        dst.to_ram = 1'b1;
                     default: dst.valid = 1'b0;
                  endcase
               end
            end
            `SOAE_QUAD_NONRAM: begin
               if (op >= soae_pkg::SOAE_OP_PASS) begin
                  case (ins.sel)
                     `SOAE_SEL_ACC, `SOAE_SEL_DATA, `SOAE_SEL_IMM,
                     `SOAE_SEL_ZERO, `SOAE_SEL_DZE, `SOAE_SEL_DSE:
                        dst.valid = 1'b1;
                     default: dst.valid = 1'b0;
                  endcase
                  case (ins.addr)
                     `SOAE_DST_Y:       ;
                     `SOAE_DST_ACC:     dst.to_acc = 1'b1;
                     `SOAE_DST_FLG:     dst.to_flg = 1'b1;
                     `SOAE_DST_ACC_FLG: begin
                        dst.to_acc = 1'b1;
                        dst.to_flg = 1'b1;
                     end
                     default: dst.valid = 1'b0;
                  endcase
               end
            end
            `SOAE_QUAD_TWO_OP: begin
               if (op < soae_pkg::SOAE_OP_PASS) begin
                  dst.valid = 1'b1;
                  case (ins.sel)
                     `SOAE_TWO_DST_ACC: dst.to_acc = 1'b1;
                     `SOAE_TWO_DST_Y:   ;
                     `SOAE_TWO_DST_RAM: dst.to_ram = 1'b1;
                     default: dst.valid = 1'b0;
                  endcase
               end
            end
            default: ;
         endcase
      end
   end

   // operation: single operand on src_a, two operand r = ram, s = acc
   always_comb begin
      src_a = pick_src(ins.sel, ram_word, acc_r, data_in, imm_in);
      src_b = (ins.quad == `SOAE_QUAD_TWO_OP) ? acc_r : src_a;
      unique case (op)
         soae_pkg::SOAE_OP_PASS:  alu = logic_res(ins.word_mode, src_a);
         soae_pkg::SOAE_OP_COMP:  alu = logic_res(ins.word_mode, ~src_a);
         soae_pkg::SOAE_OP_INC:   alu = add3(ins.word_mode, src_a, 16'h0000, 1'b1);
         soae_pkg::SOAE_OP_NEG:   alu = add3(ins.word_mode, ~src_a, 16'h0000, 1'b1);
         soae_pkg::SOAE_OP_SUBR:  alu = add3(ins.word_mode, src_b, ~ram_word, 1'b1);
         soae_pkg::SOAE_OP_SUBRC: alu = add3(ins.word_mode, src_b, ~ram_word,
                                             flg_r[`SOAE_FLG_C]);
         soae_pkg::SOAE_OP_SUBS:  alu = add3(ins.word_mode, ram_word, ~src_b, 1'b1);
         soae_pkg::SOAE_OP_SUBSC: alu = add3(ins.word_mode, ram_word, ~src_b,
                                             flg_r[`SOAE_FLG_C]);
         soae_pkg::SOAE_OP_ADD:   alu = add3(ins.word_mode, ram_word, src_b, 1'b0);
         soae_pkg::SOAE_OP_ADDC:  alu = add3(ins.word_mode, ram_word, src_b,
                                             flg_r[`SOAE_FLG_C]);
         soae_pkg::SOAE_OP_AND:   alu = logic_res(ins.word_mode, ram_word & src_b);
         soae_pkg::SOAE_OP_NAND:  alu = logic_res(ins.word_mode, ~(ram_word & src_b));
         soae_pkg::SOAE_OP_EXOR:  alu = logic_res(ins.word_mode, ram_word ^ src_b);
         soae_pkg::SOAE_OP_NOR:   alu = logic_res(ins.word_mode, ~(ram_word | src_b));
         soae_pkg::SOAE_OP_OR:    alu = logic_res(ins.word_mode, ram_word | src_b);
         soae_pkg::SOAE_OP_EXNOR: alu = logic_res(ins.word_mode, ~(ram_word ^ src_b));
      endcase
   end

   // next state of every destination
   always_comb begin
      acc_nxt = acc_r;
      flg_nxt = flg_r;
      y_nxt   = y_r;
      for (int i = 0; i < `SOAE_RAM_WORDS; i++) begin
         ram_nxt[i] = ram_r[i];
      end
      if (dst.valid) begin
         // y shows the raw result; byte mode leaves its upper half zero
         y_nxt = alu.res;
         if (dst.to_acc) begin
            acc_nxt = ins.word_mode ? alu.res : {acc_r[15:8], alu.res[7:0]};
         end
         if (dst.to_ram) begin
            ram_nxt[ins.addr] = ins.word_mode ? alu.res
                                              : {ram_word[15:8], alu.res[7:0]};
         end
         if (dst.to_flg) begin
            // flags as destination: direct load wins over computed flags
            if (ins.word_mode) begin
               flg_nxt = alu.res[`SOAE_FLG_ALL_HI:0];
            end else begin
               flg_nxt[`SOAE_FLG_LOW_HI:0] = alu.res[`SOAE_FLG_LOW_HI:0];
            end
         end else begin
            // link and user flags in the upper nibble are not touched here; only a word-mode flag load writes them
            flg_nxt[`SOAE_FLG_V] = alu.v;
            flg_nxt[`SOAE_FLG_N] = alu.n;
            flg_nxt[`SOAE_FLG_C] = alu.c;
            flg_nxt[`SOAE_FLG_Z] = alu.z;
         end
      end
   end

   // working registers are plain flops so every word clears on reset
   generate
      for (genvar g = 0; g < `SOAE_RAM_WORDS; g++) begin : g_ram
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               ram_r[g] <= `SOAE_WORD_RST;
            end else begin
               ram_r[g] <= ram_nxt[g];
            end
         end
      end
   endgenerate

   // drive flag trails the enable by a cycle so the pin comes from a flop
   always_comb begin
      ydrv_n_nxt = y_oe_n;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_r <= `SOAE_WORD_RST;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flg_r <= `SOAE_FLG_RST;
      end else begin
         flg_r <= flg_nxt;
      end
   end

   // y keeps the last result even while the bus is released
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         y_r <= `SOAE_WORD_RST;
      end else begin
         y_r <= y_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ydrv_n_r <= 1'b1;
      end else begin
         ydrv_n_r <= ydrv_n_nxt;
      end
   end

   assign y_out           = y_r;
   assign y_drive_n       = ydrv_n_r;
   assign accumulator     = acc_r;
   assign condition_flags = flg_r;

endmodule // soae_alu_exec

// ===== hdl/soae_cfg.svh
// constants for the single operand execution block
// assumes inclusion by bare name from the package and the top module
`ifndef SOAE_CFG_SVH
`define SOAE_CFG_SVH

// instruction word fields
`define SOAE_BW_BIT        15
`define SOAE_QUAD_HI       14
`define SOAE_QUAD_LO       13
`define SOAE_OPC_HI        12
`define SOAE_OPC_LO        9
`define SOAE_SEL_HI        8
`define SOAE_SEL_LO        5
`define SOAE_ADDR_HI       4
`define SOAE_ADDR_LO       0

// quadrants
`define SOAE_QUAD_TWO_OP   2'h0
`define SOAE_QUAD_RAM      2'h2
`define SOAE_QUAD_NONRAM   2'h3

// source / source-destination select codes
`define SOAE_SEL_RAM_ACC   4'h0
`define SOAE_SEL_RAM_Y     4'h2
`define SOAE_SEL_RAM_FLG   4'h3
`define SOAE_SEL_ACC       4'h4
`define SOAE_SEL_DATA      4'h6
`define SOAE_SEL_IMM       4'h7
`define SOAE_SEL_ZERO      4'h8
`define SOAE_SEL_DZE       4'h9
`define SOAE_SEL_DSE       4'ha
`define SOAE_SEL_RAM_RAM   4'hb

// two operand destination codes (r = ram word, s = accumulator)
`define SOAE_TWO_DST_ACC   4'h0
`define SOAE_TWO_DST_Y     4'h8
`define SOAE_TWO_DST_RAM   4'he

// non-ram destination codes
`define SOAE_DST_Y         5'h00
`define SOAE_DST_ACC       5'h01
`define SOAE_DST_FLG       5'h04
`define SOAE_DST_ACC_FLG   5'h05

// condition flag bit positions
`define SOAE_FLG_Z         0
`define SOAE_FLG_C         1
`define SOAE_FLG_N         2
`define SOAE_FLG_V         3
`define SOAE_FLG_LOW_HI    3
`define SOAE_FLG_ALL_HI    7

// reset values and ram word count
`define SOAE_FLG_RST       8'h00
`define SOAE_WORD_RST      16'h0000
`define SOAE_RAM_WORDS     32

`endif

// ===== hdl/soae_pkg.sv
// types for the single operand execution block
// assumes soae_cfg.svh is on the include path
package soae_pkg;
`include "soae_cfg.svh"

   typedef struct packed {
      logic       word_mode;
      logic [1:0] quad;
      logic [3:0] opcode;
      logic [3:0] sel;
      logic [4:0] addr;
   } soae_instr_t;

   typedef enum logic [3:0] {
      SOAE_OP_SUBR  = 4'h0,
      SOAE_OP_SUBRC = 4'h1,
      SOAE_OP_SUBS  = 4'h2,
      SOAE_OP_SUBSC = 4'h3,
      SOAE_OP_ADD   = 4'h4,
      SOAE_OP_ADDC  = 4'h5,
      SOAE_OP_AND   = 4'h6,
      SOAE_OP_NAND  = 4'h7,
      SOAE_OP_EXOR  = 4'h8,
      SOAE_OP_NOR   = 4'h9,
      SOAE_OP_OR    = 4'ha,
      SOAE_OP_EXNOR = 4'hb,
      SOAE_OP_PASS  = 4'hc,
      SOAE_OP_COMP  = 4'hd,
      SOAE_OP_INC   = 4'he,
      SOAE_OP_NEG   = 4'hf
   } soae_op_t;

   typedef struct packed {
      logic [15:0] res;
      logic        v;
      logic        n;
      logic        c;
      logic        z;
   } soae_alu_t;

   typedef struct packed {
      logic to_acc;
      logic to_ram;
      logic to_flg;
      logic valid;
   } soae_dest_t;

endpackage

// ===== tb/soae_alu_monitor.sv
// concurrent checks on the ports of the single operand execution block
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
module soae_alu_monitor (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        instr_valid,
   input wire logic [15:0] instr,
   input wire logic [15:0] data_in,
   input wire logic [15:0] imm_in,
   input wire logic        y_oe_n,
   input wire logic [15:0] y_out,
   input wire logic        y_drive_n,
   input wire logic [15:0] accumulator,
   input wire logic [7:0]  condition_flags
);
   logic nr_ok;

   // legal non-ram single operand word at this edge
   assign nr_ok = instr_valid && instr[14:13] == 2'h3 && instr[12:11] == 2'h3
                  && (instr[8:5] inside {4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha})
                  && (instr[4:0] inside {5'h00, 5'h01, 5'h04, 5'h05});

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   drive_follow_a: assert property (1'b1 |=> y_drive_n == $past(y_oe_n))
      else $error("y drive flag does not follow the enable");
   refused_hold_a: assert property (instr_valid && instr[14:13] == 2'h1
      |=> $stable(y_out) && $stable(accumulator) && $stable(condition_flags))
      else $error("refused quadrant changed state");
   upper_flags_a: assert property (nr_ok && !instr[2] |=> $stable(condition_flags[7:4]))
      else $error("upper flags changed");
   byte_flag_a: assert property (nr_ok && instr[2] && !instr[15]
      |=> $stable(condition_flags[7:4]) && condition_flags[3:0] == y_out[3:0])
      else $error("byte flag load wrong");
   word_flag_a: assert property (nr_ok && instr[2] && instr[15] |=> condition_flags == y_out[7:0])
      else $error("word flag load wrong");
   pass_data_a: assert property (nr_ok && instr[15] && instr[12:5] == 8'hc6 && instr[0]
      |=> accumulator == $past(data_in) && y_out == accumulator)
      else $error("data pass to accumulator wrong");
   inc_data_a: assert property (nr_ok && instr[15] && instr[12:5] == 8'he6 && !instr[2]
      |=> y_out == $past(data_in) + 16'h1 && condition_flags[3] == ($past(data_in) == 16'h7fff))
      else $error("increment result or overflow wrong");
   neg_carry_a: assert property (nr_ok && instr[15] && instr[12:5] == 8'hf6 && !instr[2]
      |=> y_out == 16'h0 - $past(data_in) && condition_flags[1] == ($past(data_in) == 16'h0))
      else $error("negate result or carry wrong");
   sign_ext_a: assert property (nr_ok && instr[15] && instr[12:5] == 8'hca
      |=> y_out == {{8{$past(data_in[7])}}, $past(data_in[7:0])})
      else $error("sign extension wrong");
   byte_keep_a: assert property (nr_ok && !instr[15] && instr[0]
      |=> $stable(accumulator[15:8]) && y_out[15:8] == 8'h00)
      else $error("byte mode touched upper byte");
   logic_flags_a: assert property (instr_valid && instr[14:13] == 2'h0
      && (instr[12:9] inside {[4'h6:4'hb]}) && (instr[8:5] inside {4'h0, 4'h8, 4'he})
      |=> !condition_flags[3] && !condition_flags[1])
      else $error("logic op left overflow or carry set");
endmodule // soae_alu_monitor

bind soae_alu_exec soae_alu_monitor u_mon (.clk(clk), .nrst(nrst), .instr_valid(instr_valid),
   .instr(instr), .data_in(data_in), .imm_in(imm_in), .y_oe_n(y_oe_n), .y_out(y_out),
   .y_drive_n(y_drive_n), .accumulator(accumulator), .condition_flags(condition_flags));

// ===== tb/soae_ucode_src.sv
// microcode source model feeding random instructions, operands and enable
// assumes it is clocked by the bench clock; drives 1 ns after each rising edge
`timescale 1ns/1ps
module soae_ucode_src (
   input  wire logic        clk,
   output logic             instr_valid,
   output logic      [15:0] instr,
   output logic      [15:0] data_in,
   output logic      [15:0] imm_in,
   output logic             y_oe_n
);
   // ram source with accumulator plus flags has no code here
   localparam logic [39:0] RAM_SEL = 40'hba98764320;
   localparam logic [23:0] NR_SEL  = 24'ha98764;
   localparam logic [11:0] TWO_SEL = 12'he80;
   localparam logic [31:0] NR_DST  = 32'h05040100;
   integer                seed;
   logic [31:0]           r;
   soae_pkg::soae_instr_t ins;

   // corner values make overflow and carry edges frequent
   function automatic logic [15:0] corner(input logic [31:0] v);
      case (v[2:0])
         3'h0: return 16'h7fff;
         3'h1: return 16'h8000;
         3'h2: return 16'h0000;
         3'h3: return 16'hffff;
         3'h4: return 16'h0080;
         default: return v[31:16];
      endcase
   endfunction

   initial begin
      seed = 32'haba94349;
      instr_valid = 1'b0;
      instr = 16'h0000;
      data_in = 16'h0000;
      imm_in = 16'h0000;
      y_oe_n = 1'b1;
   end

   always @(posedge clk) begin
      #1;
      r = $random(seed);
      ins.word_mode = r[2];
      ins.opcode = {2'h3, r[5:4]};
      ins.addr = r[16:12];
      case (r[1:0])
         2'h0: begin
            ins.quad = 2'h0;
            ins.opcode = 4'(r[9:6] % 12);
            ins.sel = TWO_SEL[4*(r[11:10] % 3) +: 4];
         end
         2'h1: begin
            ins.quad = 2'h2;
            ins.sel = RAM_SEL[4*(r[11:8] % 10) +: 4];
         end
         default: begin
            ins.quad = 2'h3;
            ins.sel = NR_SEL[4*(r[10:8] % 6) +: 4];
            ins.addr = NR_DST[8*r[14:13] +: 5];
         end
      endcase
      instr_valid = r[19:18] != 2'h0;
      // a raw word now and then exercises refusal
      instr = (r[23:20] == 4'h0) ? 16'($random(seed)) : ins;
      data_in = corner($random(seed));
      imm_in = corner($random(seed));
      y_oe_n = r[24];
   end
endmodule // soae_ucode_src

// ===== tb/test_single_operand_alu_exec.sv
// self-checking bench: reference model compared with the block every cycle
// assumes the source model and the bound monitor are compiled alongside
`timescale 1ns/1ps
module test_single_operand_alu_exec;
   logic        clk;
   logic        nrst;
   logic        instr_valid;
   logic [15:0] instr;
   logic [15:0] data_in;
   logic [15:0] imm_in;
   logic        y_oe_n;
   logic [15:0] y_out;
   logic        y_drive_n;
   logic [15:0] accumulator;
   logic [7:0]  condition_flags;
   logic [15:0] m_acc;
   logic [15:0] m_y;
   logic [15:0] m_ram [0:31];
   logic [7:0]  m_flg;
   logic        m_drv;
   integer      n_mismatch;
   integer      num_checks;
   integer      cycles;

   soae_alu_exec u_dut (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
      .data_in(data_in), .imm_in(imm_in), .y_oe_n(y_oe_n), .y_out(y_out),
      .y_drive_n(y_drive_n), .accumulator(accumulator), .condition_flags(condition_flags));
   soae_ucode_src u_src (.clk(clk), .instr_valid(instr_valid), .instr(instr),
      .data_in(data_in), .imm_in(imm_in), .y_oe_n(y_oe_n));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic exec();
      soae_pkg::soae_instr_t i;
      logic [15:0] msk;
      logic [15:0] s;
      logic [15:0] r;
      logic [15:0] a;
      logic [15:0] b;
      logic [16:0] sum;
      logic        cin;
      logic        ar;
      logic [2:0]  dst;
      int          w;
      i = instr;
      msk = i.word_mode ? 16'hffff : 16'h00ff;
      w = i.word_mode ? 15 : 7;
      case (i.sel)
         4'h4: s = m_acc;
         4'h6: s = data_in;
         4'h7: s = imm_in;
         4'h8: s = 16'h0000;
         4'h9: s = {8'h00, data_in[7:0]};
         4'ha: s = {{8{data_in[7]}}, data_in[7:0]};
         default: s = m_ram[i.addr];
      endcase
      b = 16'h0000;
      r = 16'h0000;
      if (i.quad == 2'h0) begin
         if (i.opcode > 4'hb || !(i.sel inside {4'h0, 4'h8, 4'he})) return;
         dst = {i.sel == 4'h0, i.sel == 4'he, 1'b0};
         ar = i.opcode < 4'h6;
         a = i.opcode[2:1] == 2'h0 ? m_acc : m_ram[i.addr];
         b = i.opcode[2:1] == 2'h0 ? ~m_ram[i.addr] : (i.opcode[1] ? ~m_acc : m_acc);
         cin = i.opcode[0] ? m_flg[1] : i.opcode < 4'h4;
         case (i.opcode)
            4'h6: r = m_ram[i.addr] & m_acc;
            4'h7: r = ~(m_ram[i.addr] & m_acc);
            4'h8: r = m_ram[i.addr] ^ m_acc;
            4'h9: r = ~(m_ram[i.addr] | m_acc);
            4'ha: r = m_ram[i.addr] | m_acc;
            default: r = ~(m_ram[i.addr] ^ m_acc);
         endcase
      end else begin
         if (i.opcode < 4'hc || i.quad == 2'h1) return;
         if (i.quad == 2'h3) begin
            if (!(i.sel inside {4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha})) return;
            if (!(i.addr inside {5'h00, 5'h01, 5'h04, 5'h05})) return;
            dst = {i.addr[0], 1'b0, i.addr[2]};
         end else begin
            if (i.sel == 4'h1 || i.sel == 4'h5 || i.sel > 4'hb) return;
            dst = {i.sel == 4'h0, i.sel > 4'h3, i.sel == 4'h3};
         end
         ar = i.opcode[1];
         a = i.opcode[0] ? ~s : s;
         cin = i.opcode[1];
      end
      a = a & msk;
      b = b & msk;
      sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
      if (ar || i.quad != 2'h0) r = sum[15:0];
      r = r & msk;
      m_y = r;
      if (dst[0]) begin
         if (i.word_mode) m_flg = r[7:0];
         else m_flg[3:0] = r[3:0];
      end else begin
         m_flg[3:0] = {ar && a[w] == b[w] && r[w] != a[w], r[w],
                       ar && (i.word_mode ? sum[16] : sum[8]), r == 16'h0000};
      end
      if (dst[2]) m_acc = (m_acc & ~msk) | r;
      if (dst[1]) m_ram[i.addr] = (m_ram[i.addr] & ~msk) | r;
   endtask

   task automatic stop_test();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always #2.5 clk = ~clk;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         m_acc = 16'h0000;
         m_y = 16'h0000;
         m_flg = 8'h00;
         m_drv = 1'b1;
         for (int k = 0; k < 32; k++) m_ram[k] = 16'h0000;
      end else begin
         m_drv = y_oe_n;
         if (instr_valid) exec();
      end
   end

   always @(negedge clk) begin
      if (cycles > 1) begin
         check("y_out", y_out, m_y);
         check("accumulator", accumulator, m_acc);
         check("condition_flags", {8'h00, condition_flags}, {8'h00, m_flg});
         check("y_drive_n", {15'h0000, y_drive_n}, {15'h0000, m_drv});
      end
   end

   // run is about 6012 cycles
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles >= 8000) begin
         n_mismatch = n_mismatch + 1;
         stop_test();
      end
   end

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      n_mismatch = 0;
      num_checks = 0;
      cycles = 0;
      repeat (6) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3000) @(posedge clk);
      // second reset in mid-run
      #1 nrst = 1'b0;
      repeat (6) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3000) @(posedge clk);
      stop_test();
   end
endmodule // test_single_operand_alu_exec
